// *** xcvr_consts.svh ***
// Constants of the transceiver control sequencer
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH
`define WORD_BITS        25
`define SHORT_BITS       16
`define RECOV_BIT        24
`define GAUSS_LSB        9
`define REFC_RATIO       4
`define SETTLE_US        200
`define CORE_MHZ         40
`define SETTLE_CYCLES    (`SETTLE_US * `CORE_MHZ)
`define FIFO_DEPTH       8
`endif

// *** xcvr_pkg.sv ***
// Types of the transceiver control sequencer
package xcvr_pkg;
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_IDLE   = 2'b01,
    ST_SETTLE = 2'b10,
    ST_READY  = 2'b11
  } seq_state_e;
endpackage

// *** data_fifo.sv ***
// Small FIFO with valid and ready on both sides
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic [AW+1:0]    fill_d;
  logic             rdy_q, rdy_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic             ov_q, ov_d;
  logic             push, pop, empty;
  // Pointers carry one extra bit so full and empty are told apart
  always_comb begin
    empty    = (wp_q == rp_q);
    push     = in_valid && rdy_q;
    pop      = !empty && (!ov_q || out_ready);
    wp_d     = push ? wp_q + 1'b1 : wp_q;
    rp_d     = pop ? rp_q + 1'b1 : rp_q;
    od_d     = pop ? mem_q[rp_q[AW-1:0]] : od_q;
    ov_d     = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    // Output register counts as a slot, else the FIFO would hold DEPTH plus one
    fill_d   = {1'b0, wp_d - rp_d} + {{(AW+1){1'b0}}, ov_d};
    rdy_d    = (fill_d < (AW+2)'(DEPTH));
  end
  // Storage has no reset; pointers, output word, valid and ready flags do
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
  // Output word is held in a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      od_q <= '0;
      ov_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      od_q <= od_d;
      ov_q <= ov_d;
      rdy_q <= rdy_d;
    end
  end
  assign in_ready  = rdy_q;
  assign out_data  = od_q;
  assign out_valid = ov_q;
endmodule

// *** xcvr_sequencer.sv ***
// Transceiver control sequencer: serial load, PLL settling, slot data paths
// Functional notes
// - Power-up enables synthesizer and oscillator blocks; only synth_enable is driven here, there is no oscillator enable output
// - Enable falling starts transfer; shift while low
// - Enable rising latches shifted word
// - PLL settling starts at latch, except a latch in the power-up cycle (sequence only goes idle)
// - Internal timing derived from reference clock
// - Receive slot outputs data with clock
// - Shift on rising clock, MSB first
// - No bit count; last bits kept
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module xcvr_sequencer #(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter int FIFO_DEPTH    = `FIFO_DEPTH
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  ser_clk,
  input  wire logic                  regulator_power_up,
  input  wire logic                  transceiver_power_up,
  input  wire logic                  ser_data,
  input  wire logic                  ser_enable_n,
  input  wire logic                  rx_on,
  input  wire logic                  tx_on,
  input  wire logic                  open_loop_disable_n,
  input  wire logic                  tx_data,
  input  wire logic                  demod_bit,
  input  wire logic                  demod_valid,
  output logic                       demod_ready,
  output logic                       synth_enable,
  output logic                       pll_locked,
  output logic                       recovery_on,
  output logic [`WORD_BITS-1:0]      active_word,
  output logic                       modulate,
  output logic                       tx_sample,
  output logic                       rx_data,
  output logic                       rx_clock
);
  import xcvr_pkg::*;
  initial begin
    if (SETTLE_CYCLES < 1) $error("SETTLE_CYCLES must be at least one");
  end

  // ------------------------------------------------------------
  // Serial shift register on the link clock
  // ------------------------------------------------------------
  logic [`WORD_BITS-1:0] shift_q, shift_d;
  // Shift only while enable is low; no bit count so old bits fall off the top
  always_comb begin
    shift_d = shift_q;
    if (!ser_enable_n) begin
      shift_d = {shift_q[`WORD_BITS-2:0], ser_data};
    end
  end
  // Link clock only runs inside a transfer, so no logic here waits on it
  always_ff @(posedge ser_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers into the core domain
  // ------------------------------------------------------------
  logic [6:0] s1_q, s2_q, s3_q;
  logic [6:0] pins;
  assign pins = {ser_enable_n, transceiver_power_up, regulator_power_up,
                 rx_on, tx_on, open_loop_disable_n, tx_data};
  // Two stages per pin; third stage only for enable edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 7'h40;
      s2_q <= 7'h40;
      s3_q <= 7'h40;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic en_rise, pwr_on, rx_s, tx_s, olen_s, txd_s;
  assign en_rise = s2_q[6] && !s3_q[6];
  assign pwr_on  = s2_q[5] && s2_q[4];
  assign rx_s    = s2_q[3];
  assign tx_s    = s2_q[2];
  assign olen_s  = s2_q[1];
  assign txd_s   = s2_q[0];

  // ------------------------------------------------------------
  // Word latch and settling sequence
  // ------------------------------------------------------------
  seq_state_e            st_q, st_d;
  logic [31:0]           cnt_q, cnt_d;
  logic [`WORD_BITS-1:0] word_q, word_d;
  logic                  rec_q, rec_d;
  logic                  syn_q, syn_d, lock_q, lock_d;
  // Shift register is stable once enable is high two core cycles, so
  // reading it across domains at the enable edge is safe
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    word_d = word_q;
    rec_d  = rec_q;
    if (pwr_on && en_rise) begin
      word_d = shift_q;
      rec_d  = shift_q[`RECOV_BIT];
    end
    case (st_q)
      ST_OFF: begin
        if (pwr_on) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE, ST_SETTLE, ST_READY: begin
        if (!pwr_on) begin
          st_d = ST_OFF;
        end else if (en_rise) begin
          st_d  = ST_SETTLE;
          cnt_d = 32'(SETTLE_CYCLES - 1);
        end else if (st_q == ST_SETTLE) begin
          if (cnt_q == 32'h0000_0000) begin
            st_d = ST_READY;
          end else begin
            cnt_d = cnt_q - 32'h0000_0001;
          end
        end
      end
      default: st_d = ST_OFF;
    endcase
    // Status follows the next state so both outputs leave straight from flops
    syn_d  = (st_d != ST_OFF);
    lock_d = (st_d == ST_READY);
  end
  // Sequence registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= ST_OFF;
      cnt_q  <= '0;
      word_q <= '0;
      rec_q  <= 1'b0;
      syn_q  <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      word_q <= word_d;
      rec_q  <= rec_d;
      syn_q  <= syn_d;
      lock_q <= lock_d;
    end
  end

  // ------------------------------------------------------------
  // Reference-derived timing, transmit sampling, receive output
  // ------------------------------------------------------------
  logic [1:0] div_q, div_d;
  logic       mod_q, mod_d, txs_q, txs_d;
  logic       rxd_q, rxd_d, rxc_q, rxc_d, pop;
  logic       f_bit, f_valid;
  // Sample tick from the core reference divider; data changes on the
  // rising recovered clock so the host samples it on the falling one
  always_comb begin
    div_d = (st_q == ST_OFF) ? 2'h0 : div_q + 2'h1;
    mod_d = (st_q == ST_READY) && tx_s && !rx_s && !olen_s;
    txs_d = (div_q == 2'h0 && mod_q) ? txd_s : txs_q;
    pop   = (st_q == ST_READY) && rx_s && !tx_s && (div_q == 2'h0) && f_valid;
    rxd_d = pop ? f_bit : rxd_q;
    rxc_d = pop ? 1'b1 : ((div_q == 2'h2) ? 1'b0 : rxc_q);
  end
  // Timing registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 2'h0;
      mod_q <= 1'b0;
      txs_q <= 1'b0;
      rxd_q <= 1'b0;
      rxc_q <= 1'b0;
    end else begin
      div_q <= div_d;
      mod_q <= mod_d;
      txs_q <= txs_d;
      rxd_q <= rxd_d;
      rxc_q <= rxc_d;
    end
  end

  // Receive bits queue here; back-pressure reaches the demodulator
  data_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (reset_n),
    .in_data   (demod_bit),
    .in_valid  (demod_valid),
    .in_ready  (demod_ready),
    .out_data  (f_bit),
    .out_valid (f_valid),
    .out_ready (pop)
  );

  assign synth_enable = syn_q;
  assign pll_locked   = lock_q;
  assign recovery_on  = rec_q;
  assign active_word  = word_q;
  assign modulate     = mod_q;
  assign tx_sample    = txs_q;
  assign rx_data      = rxd_q;
  assign rx_clock     = rxc_q;
endmodule

// *** xcvr_sequencer_props.sv ***
// Checker of the control sequencer outputs
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module xcvr_sequencer_chk (
  input wire logic                  core_clk,
  input wire logic                  reset_n,
  input wire logic                  transceiver_power_up,
  input wire logic                  synth_enable,
  input wire logic                  pll_locked,
  input wire logic                  recovery_on,
  input wire logic [`WORD_BITS-1:0] active_word,
  input wire logic                  modulate,
  input wire logic                  tx_sample,
  input wire logic                  rx_data,
  input wire logic                  rx_clock
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Recovered clock: two cycles high, then low
  sequence s_clk_high; rx_clock [*2]; endsequence
  sequence s_clk_low; !rx_clock; endsequence
  a_clk_pulse: assert property ($rose(rx_clock) |-> s_clk_high ##1 s_clk_low)
    else $error("recovered clock pulse wrong");
  a_data_edge: assert property ($changed(rx_data) |-> $rose(rx_clock))
    else $error("receive data moved off clock edge");
  a_clk_locked: assert property ($rose(rx_clock) |-> pll_locked)
    else $error("receive clock while unlocked");
  a_recov_bit: assert property (recovery_on == active_word[`RECOV_BIT])
    else $error("recovery flag differs from word");
  a_word_unlocks: assert property ($changed(active_word) |-> !pll_locked)
    else $error("latch did not restart settling");
  a_mod_locked: assert property (modulate |-> $past(pll_locked))
    else $error("modulation while unlocked");
  a_sample_mod: assert property ($changed(tx_sample) |-> $past(modulate) || !tx_sample)
    else $error("transmit sample outside modulation");
  a_synth_off: assert property (!transceiver_power_up [*4] |-> !synth_enable)
    else $error("synthesizer on while unpowered");
endmodule

bind xcvr_sequencer xcvr_sequencer_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .transceiver_power_up(transceiver_power_up), .synth_enable(synth_enable),
  .pll_locked(pll_locked), .recovery_on(recovery_on), .active_word(active_word),
  .modulate(modulate), .tx_sample(tx_sample), .rx_data(rx_data), .rx_clock(rx_clock));

// *** xcvr_host_model.sv ***
// Host model driving the three-wire programming link
`timescale 1ns/1ps
module xcvr_host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic ser_enable_n
);
  // ----------------------------------------
  // Serial transfer
  // ----------------------------------------
  initial begin
    {ser_clk, ser_data, ser_enable_n} = 3'b001;
  end
  // Clock runs only inside a frame; stops well before enable rises
  task automatic send(input logic [31:0] w, input int n);
    #7 ser_enable_n = 0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = w[i];
      #24 ser_clk = 1;
      #24 ser_clk = 0;
    end
    #100 ser_enable_n = 1;
    ser_data = ~ser_data; // Released line shows no stale bit
    #300;
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench of the control sequencer
`timescale 1ns/1ps
`include "xcvr_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t ns value mismatch", $time); end end
module testbench;
  logic core_clk, reset_n, ser_clk, ser_data, ser_enable_n, regulator_power_up;
  logic transceiver_power_up, rx_on, tx_on, open_loop_disable_n, tx_data, rxc_q;
  logic demod_bit, demod_valid, demod_ready, synth_enable, pll_locked, recovery_on;
  logic modulate, tx_sample, rx_data, rx_clock;
  logic [`WORD_BITS-1:0] active_word, pw, aw_q = '0;
  logic [`WORD_BITS-1:0] wq[$];
  logic bq[$];
  logic [31:0] r;
  int failures = 0, n_tests = 0, n;
  // ----------------------------------------
  // Instances and clock
  // ----------------------------------------
  xcvr_sequencer #(.SETTLE_CYCLES(20)) u_dut (.core_clk, .reset_n, .ser_clk,
    .regulator_power_up, .transceiver_power_up, .ser_data, .ser_enable_n, .rx_on,
    .tx_on, .open_loop_disable_n, .tx_data, .demod_bit, .demod_valid, .demod_ready,
    .synth_enable, .pll_locked, .recovery_on, .active_word, .modulate, .tx_sample,
    .rx_data, .rx_clock);
  xcvr_host_model u_host (.ser_clk, .ser_data, .ser_enable_n);
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  task automatic final_report;
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watcher: each latched word and each received bit meets its oldest note
  always @(posedge core_clk) begin
    if (reset_n === 1'b1 && active_word !== aw_q) begin
      if (wq.size() == 0) `CHK(1'b0, 1'b1)
      else `CHK(active_word, wq.pop_front())
    end
    if (reset_n === 1'b1 && rx_clock === 1'b1 && rxc_q !== 1'b1)
      `CHK(rx_data, bq.size() ? bq.pop_front() : 1'bx)
    aw_q <= active_word;
    rxc_q <= rx_clock;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    final_report;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset_n, regulator_power_up, transceiver_power_up, rx_on, tx_on} = '0;
    {tx_data, demod_bit, demod_valid, open_loop_disable_n} = 4'h1;
    r = 32'h46;
    repeat (3) @(posedge core_clk);
    reset_n <= 1;
    @(posedge core_clk);
    `CHK(active_word, 25'h0)
    `CHK(demod_ready, 1'b1)
    {regulator_power_up, transceiver_power_up} <= 2'h3;
    repeat (1600) @(posedge core_clk);
    `CHK(synth_enable, 1'b1)
    // Full word, short word over leftovers, then surplus leading bits
    r = lfsr(r);
    pw = r[24:0];
    wq.push_back(pw);
    u_host.send(r, 25);
    r = lfsr(r);
    wq.push_back({pw[8:0], r[15:0]});
    u_host.send(r, 16);
    r = lfsr(r);
    wq.push_back(r[24:0]);
    u_host.send(r, 30);
    @(posedge core_clk);
    `CHK(pll_locked, 1'b0)
    `CHK(recovery_on, r[`RECOV_BIT])
    for (n = 0; n < 60 && pll_locked !== 1'b1; n++) @(posedge core_clk);
    `CHK(n inside {[5:20]}, 1'b1)
    // Fill the FIFO while the slot is closed, then drain it
    demod_valid <= 1;
    demod_bit <= r[0];
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      if (demod_ready === 1'b1) begin
        bq.push_back(demod_bit);
        r = lfsr(r);
        demod_bit <= r[0];
      end
    end
    demod_valid <= 0;
    #1 `CHK(demod_ready, 1'b0)
    `CHK(bq.size(), 8)
    rx_on <= 1;
    repeat (100) @(posedge core_clk);
    `CHK(bq.size(), 0)
    // Transmit slot: preamble, then open loop
    rx_on <= 0;
    tx_on <= 1;
    for (int i = 0; i < 16; i++) begin
      tx_data <= ~i[0];
      @(posedge core_clk);
    end
    open_loop_disable_n <= 0;
    tx_data <= 1;
    repeat (12) @(posedge core_clk);
    `CHK(modulate, 1'b1)
    `CHK(tx_sample, 1'b1)
    rx_on <= 1;
    repeat (6) @(posedge core_clk);
    `CHK(modulate, 1'b0)
    // Unpowered: the latch must be ignored
    {rx_on, tx_on, transceiver_power_up} <= 3'h0;
    repeat (6) @(posedge core_clk);
    `CHK(synth_enable, 1'b0)
    u_host.send(32'h01ABCDEF, 25);
    repeat (10) @(posedge core_clk);
    `CHK(wq.size(), 0)
    final_report;
  end
endmodule
